// file: src/dcst_consts.svh
// register map, field layout and reset values of the spacing timer
`ifndef DCST_CONSTS_SVH
`define DCST_CONSTS_SVH

// register bus and bank geometry
`define DCST_ADDR_W         4
`define DCST_DATA_W         32
`define DCST_BANKS          8
`define DCST_BANK_W         3

// byte offsets of the registers
`define DCST_OFS_TIMING     4'h0
`define DCST_OFS_CONFIG     4'h4
`define DCST_OFS_STATUS     4'h8

// timing register field positions
`define DCST_RFC_HI         31
`define DCST_RFC_LO         25
`define DCST_RP_HI          24
`define DCST_RP_LO          22
`define DCST_RCD_HI         21
`define DCST_RCD_LO         19
`define DCST_WR_HI          18
`define DCST_WR_LO          16
`define DCST_RAS_HI         15
`define DCST_RAS_LO         11
`define DCST_RC_HI          10
`define DCST_RC_LO          6
`define DCST_RRD_HI         5
`define DCST_RRD_LO         3
`define DCST_RSVD_BIT       2
`define DCST_WTR_HI         1
`define DCST_WTR_LO         0

// timing register reset values per field
`define DCST_RST_RFC        7'h2a
`define DCST_RST_RP         3'h4
`define DCST_RST_RCD        3'h4
`define DCST_RST_WR         3'h4
`define DCST_RST_RAS        5'h0e
`define DCST_RST_RC         5'h0b
`define DCST_RST_RRD        3'h3
`define DCST_RST_RSVD       1'h0
`define DCST_RST_WTR        2'h2

// configuration register bits and reset value
`define DCST_CFG_ENABLE_BIT 0
`define DCST_CFG_UNLOCK_BIT 1
`define DCST_CFG_W          2
`define DCST_RST_CFG        2'h0

// status register bit positions
`define DCST_ST_ACT_LO      0
`define DCST_ST_PRE_LO      8
`define DCST_ST_REF_BIT     16
`define DCST_ST_RD_BIT      17
`define DCST_ST_WR_BIT      18

`endif

// file: src/dcst_pkg.sv
// shared types of the command spacing timer
package dcst_pkg;
	typedef logic [31:0] dcst_word_t;   // one register word
	typedef logic [2:0]  dcst_bank_t;   // bank number
	typedef logic [7:0]  dcst_bankv_t;  // one bit per bank
	// register selected by the bus address
	typedef enum logic [1:0] {
		DCST_SEL_TIMING,
		DCST_SEL_CONFIG,
		DCST_SEL_STATUS,
		DCST_SEL_NONE
	} dcst_sel_t;
endpackage

// file: src/dcst_reset_sync.sv
// reset release synchroniser
`timescale 1ns/10ps
module dcst_reset_sync
(
	input  wire logic clock_in,   // system clock
	input  wire logic nrst_in,    // raw reset, active low
	output logic      nrst_out    // reset with synchronous release
);
	logic stage_q;                // first stage, read only by the second

	// assert at once, release after two edges
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			stage_q  <= 1'b0;
			nrst_out <= 1'b0;
		end
		else
		begin
			stage_q  <= 1'b1;
			nrst_out <= stage_q;
		end
	end
endmodule

// file: src/dcst_gap_counter.sv
// one spacing down-counter with a zero flag
`timescale 1ns/10ps
module dcst_gap_counter
#(
	parameter int W = 3           // field width
)
(
	input  wire logic         clock_in,   // system clock
	input  wire logic         nrst_in,    // synchronous-release reset
	input  wire logic         load_in,    // triggering command this cycle
	input  wire logic [W-1:0] value_in,   // field value, count minus one
	output logic              done_d_out, // next-cycle eligibility
	output logic              done_q_out  // eligibility now
);
	logic [W-1:0] cnt_q;          // remaining cycles
	logic [W-1:0] cnt_d;          // next remaining cycles

	// load on trigger, else count down and stop at zero
	assign cnt_d      = load_in ? value_in :
	                    (cnt_q != '0) ? cnt_q - {{(W-1){1'b0}}, 1'b1} : cnt_q;
	assign done_d_out = (cnt_d == '0);

	// counter starts idle, so every command is eligible after reset
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt_q      <= '0;
			done_q_out <= 1'b1;
		end
		else
		begin
			cnt_q      <= cnt_d;
			done_q_out <= done_d_out;
		end
	end
endmodule

// file: src/dcst_timer.sv
// command spacing timer: timing register, config register and gap counters
`timescale 1ns/10ps
`include "dcst_consts.svh"
module dcst_timer
(
	input  wire logic                    clock_in,        // memory output clock
	input  wire logic                    nrst_in,         // reset, active low
	// register port
	// one-cycle strobes, read data in the cycle after
	input  wire logic [`DCST_ADDR_W-1:0] reg_addr_in,     // byte address
	input  wire logic [`DCST_DATA_W-1:0] reg_wdata_in,    // write data
	input  wire logic                    reg_wr_in,       // write strobe
	input  wire logic                    reg_rd_in,       // read strobe
	output logic [`DCST_DATA_W-1:0]      reg_rdata_out,   // read data, next cycle
	// commands issued by the controller, same clock
	// same clock as the core, so no synchroniser
	input  wire logic                    cmd_refresh_in,  // refresh issued
	input  wire logic                    cmd_mode_load_in,// mode-register load issued
	input  wire logic                    cmd_precharge_in,// precharge issued
	input  wire logic                    cmd_activate_in, // activate issued
	input  wire logic [`DCST_BANK_W-1:0] cmd_bank_in,     // bank of the activate
	input  wire logic                    cmd_read_in,     // read issued
	input  wire logic                    wr_data_last_in, // final write data transfer
	// eligibility toward the command scheduler
	// registered levels, high while the command may go
	output logic [`DCST_BANKS-1:0]       activate_ok_out, // activate allowed per bank
	output logic [`DCST_BANKS-1:0]       precharge_ok_out,// precharge allowed per bank
	output logic                         refresh_ok_out,  // refresh allowed
	output logic                         read_ok_out,     // read allowed
	output logic                         write_ok_out,    // write allowed
	output logic                         init_start_out,  // start initialization, pulse
	output logic                         ctrl_enable_out  // controller enable bit
);
	// synchronised reset used by everything below
	// all flops leave reset on one edge, so no counter
	// wakes up half way through a gap
	logic                        rst_n;

	// register state
	// timing word kept whole; reserved bit always stored as zero
	dcst_pkg::dcst_word_t        timing_q;        // timing set one
	dcst_pkg::dcst_word_t        timing_d;        // next timing set one
	logic [`DCST_CFG_W-1:0]      cfg_q;           // enable and unlock bits
	logic [`DCST_CFG_W-1:0]      cfg_d;           // next config
	logic                        init_start_d;    // next init request

	// decoded bus access
	// reads and writes share one address map
	dcst_pkg::dcst_sel_t         sel;             // register under the address
	logic                        wr_timing;       // write aimed at timing word
	logic                        wr_timing_ok;    // that write is accepted
	logic                        wr_config;       // write aimed at config
	logic                        wr_changed;      // write-recovery field changes
	dcst_pkg::dcst_word_t        status_word;     // live eligibility view
	dcst_pkg::dcst_word_t        rd_mux;          // selected read value
	dcst_pkg::dcst_word_t        rdata_d;         // next read data

	// unpacked timing fields
	// each field is the gap minus one, as loaded
	logic [6:0]                  f_rfc;           // refresh cycle
	logic [2:0]                  f_rp;            // precharge period
	logic [2:0]                  f_rcd;           // row to column
	logic [2:0]                  f_wr;            // write recovery
	logic [4:0]                  f_ras;           // row active
	logic [4:0]                  f_rc;            // row cycle
	logic [2:0]                  f_rrd;           // row to row
	logic [1:0]                  f_wtr;           // write to read

	// counter results, next-cycle view
	// lets a grant drop on the edge that takes
	// the triggering command
	logic                        rfc_done;        // refresh/mode gap over
	logic                        rp_done;         // precharge gap over
	logic                        rcd_done;        // activate to column gap over
	logic                        wr_done;         // write recovery over
	logic                        rrd_done;        // bank to bank gap over
	logic                        wtr_done;        // write to read gap over
	dcst_pkg::dcst_bankv_t       ras_done;        // per bank row active over
	dcst_pkg::dcst_bankv_t       rc_done;         // per bank row cycle over
	dcst_pkg::dcst_bankv_t       act_hit;         // activate aimed at each bank

	// next eligibility
	// high: the command may issue next cycle
	dcst_pkg::dcst_bankv_t       act_ok_d;        // activate per bank
	dcst_pkg::dcst_bankv_t       pre_ok_d;        // precharge per bank
	logic                        ref_ok_d;        // refresh
	logic                        rd_ok_d;         // read
	logic                        wrc_ok_d;        // write

	// field extraction used for both stored and written words
	// one helper keeps compare and split in step
	function automatic logic [2:0] wr_field(input dcst_pkg::dcst_word_t w);
		wr_field = w[`DCST_WR_HI:`DCST_WR_LO];
	endfunction

	// reset release
	// asserts at once, releases through two flops
	dcst_reset_sync u_rst
	(
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.nrst_out (rst_n)
	);

	// address decode
	// other offsets read zero and take no write
	assign sel = (reg_addr_in == `DCST_OFS_TIMING) ? dcst_pkg::DCST_SEL_TIMING :
	             (reg_addr_in == `DCST_OFS_CONFIG) ? dcst_pkg::DCST_SEL_CONFIG :
	             (reg_addr_in == `DCST_OFS_STATUS) ? dcst_pkg::DCST_SEL_STATUS :
	             dcst_pkg::DCST_SEL_NONE;

	assign wr_timing    = reg_wr_in && (sel == dcst_pkg::DCST_SEL_TIMING);
	assign wr_config    = reg_wr_in && (sel == dcst_pkg::DCST_SEL_CONFIG);
	// a locked timing word silently keeps its fields
	// no error flag: software must read back to know
	assign wr_timing_ok = wr_timing && cfg_q[`DCST_CFG_UNLOCK_BIT];
	assign wr_changed   = (wr_field(reg_wdata_in) != wr_field(timing_q));

	// timing word next value; reserved bit is forced low on every write
	// done here so the read path needs no special case
	assign timing_d = wr_timing_ok ?
	                  {reg_wdata_in[31:`DCST_RSVD_BIT+1], 1'b0,
	                   reg_wdata_in[`DCST_RSVD_BIT-1:0]} :
	                  timing_q;
	assign cfg_d    = wr_config ? reg_wdata_in[`DCST_CFG_W-1:0] : cfg_q;

	// new write recovery while enabled restarts initialization
	// enable and compare use values held before the write;
	// writing the same field value again restarts nothing
	assign init_start_d = wr_timing_ok && wr_changed &&
	                      cfg_q[`DCST_CFG_ENABLE_BIT];

	// registers
	// init request is a pulse: it is recomputed
	// from the strobe on every cycle
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timing_q       <= {`DCST_RST_RFC, `DCST_RST_RP, `DCST_RST_RCD,
			                   `DCST_RST_WR, `DCST_RST_RAS, `DCST_RST_RC,
			                   `DCST_RST_RRD, `DCST_RST_RSVD, `DCST_RST_WTR};
			cfg_q          <= `DCST_RST_CFG;
			init_start_out <= 1'b0;
		end
		else
		begin
			timing_q       <= timing_d;
			cfg_q          <= cfg_d;
			init_start_out <= init_start_d;
		end
	end

	// enable bit is also handed to the controller core
	// fed from the next config value, so the copy
	// changes in the same cycle as the bit itself
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_enable_out <= 1'b0;
		else
			ctrl_enable_out <= cfg_d[`DCST_CFG_ENABLE_BIT];
	end

	// status view: what the scheduler currently sees
	// built from the very grant flops, no extra lag
	assign status_word = {13'h0000, write_ok_out, read_ok_out, refresh_ok_out,
	                      precharge_ok_out, activate_ok_out};

	// read select; unmapped addresses read zero
	assign rd_mux = (sel == dcst_pkg::DCST_SEL_TIMING) ? timing_q :
	                (sel == dcst_pkg::DCST_SEL_CONFIG) ? {30'h00000000, cfg_q} :
	                (sel == dcst_pkg::DCST_SEL_STATUS) ? status_word :
	                32'h00000000;
	// read data holds only for the cycle after the strobe
	// zero outside reads keeps a shared bus quiet,
	// at the cost of one gate in the read path
	assign rdata_d = reg_rd_in ? rd_mux : 32'h00000000;

	// read data register
	// registered so data never follow a later address
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_out <= 32'h00000000;
		else
			reg_rdata_out <= rdata_d;
	end

	// field split, from the stored word only
	// a new field counts from the next trigger on;
	// a gap already running keeps its old length
	assign f_rfc = timing_q[`DCST_RFC_HI:`DCST_RFC_LO];
	assign f_rp  = timing_q[`DCST_RP_HI:`DCST_RP_LO];
	assign f_rcd = timing_q[`DCST_RCD_HI:`DCST_RCD_LO];
	assign f_wr  = wr_field(timing_q);
	assign f_ras = timing_q[`DCST_RAS_HI:`DCST_RAS_LO];
	assign f_rc  = timing_q[`DCST_RC_HI:`DCST_RC_LO];
	assign f_rrd = timing_q[`DCST_RRD_HI:`DCST_RRD_LO];
	assign f_wtr = timing_q[`DCST_WTR_HI:`DCST_WTR_LO];

	// refresh or mode load opens the refresh-cycle gap
	// seven bits: the longest gap in the word
	dcst_gap_counter #(.W(7)) u_rfc
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (cmd_refresh_in | cmd_mode_load_in),
		.value_in   (f_rfc),
		.done_d_out (rfc_done),
		.done_q_out ()
	);

	// any precharge opens the precharge gap; tracked globally, so a
	// precharge to one bank also holds off activates elsewhere
	// trades some bandwidth for one counter, not eight
	dcst_gap_counter #(.W(3)) u_rp
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (cmd_precharge_in),
		.value_in   (f_rp),
		.done_d_out (rp_done),
		.done_q_out ()
	);

	// activate to column command, conservative across banks
	// a column command may wait longer than needed,
	// never shorter
	dcst_gap_counter #(.W(3)) u_rcd
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (cmd_activate_in),
		.value_in   (f_rcd),
		.done_d_out (rcd_done),
		.done_q_out ()
	);

	// final write data to precharge
	// global: one write holds precharge of all banks
	dcst_gap_counter #(.W(3)) u_wr
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (wr_data_last_in),
		.value_in   (f_wr),
		.done_d_out (wr_done),
		.done_q_out ()
	);

	// activate to activate in another bank; also applied to the same
	// bank, harmless because the row-cycle gap there is longer
	dcst_gap_counter #(.W(3)) u_rrd
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (cmd_activate_in),
		.value_in   (f_rrd),
		.done_d_out (rrd_done),
		.done_q_out ()
	);

	// last write to read
	// writes themselves are never held by this gap
	dcst_gap_counter #(.W(2)) u_wtr
	(
		.clock_in   (clock_in),
		.nrst_in    (rst_n),
		.load_in    (wr_data_last_in),
		.value_in   (f_wtr),
		.done_d_out (wtr_done),
		.done_q_out ()
	);

	// per-bank row active and row cycle counters
	// truly per bank, so each bank has its own pair;
	// the bank number counts only beside an activate
	generate
		for (genvar b = 0; b < `DCST_BANKS; b++)
		begin : g_bank
			assign act_hit[b] = cmd_activate_in &&
			                    (cmd_bank_in == dcst_pkg::dcst_bank_t'(b));

			// activate to precharge of this bank
			dcst_gap_counter #(.W(5)) u_ras
			(
				.clock_in   (clock_in),
				.nrst_in    (rst_n),
				.load_in    (act_hit[b]),
				.value_in   (f_ras),
				.done_d_out (ras_done[b]),
				.done_q_out ()
			);

			// activate to activate of this bank
			dcst_gap_counter #(.W(5)) u_rc
			(
				.clock_in   (clock_in),
				.nrst_in    (rst_n),
				.load_in    (act_hit[b]),
				.value_in   (f_rc),
				.done_d_out (rc_done[b]),
				.done_q_out ()
			);
		end
	endgenerate

	// combine the gaps into per-command eligibility
	// allowed only when every guarding gap is over;
	// a read starts no gap, so its strobe gates nothing
	assign act_ok_d = rc_done & {`DCST_BANKS{rfc_done & rp_done & rrd_done}};
	assign pre_ok_d = ras_done & {`DCST_BANKS{wr_done}};
	assign ref_ok_d = rfc_done & rp_done;
	assign rd_ok_d  = rcd_done & wtr_done;
	assign wrc_ok_d = rcd_done;

	// eligibility flops; they see a command's own load in the same edge,
	// so a gated command never sees a stale grant
	// grants start high: after reset no gap is open
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			activate_ok_out  <= 8'hff;
			precharge_ok_out <= 8'hff;
			refresh_ok_out   <= 1'b1;
			read_ok_out      <= 1'b1;
			write_ok_out     <= 1'b1;
		end
		else
		begin
			activate_ok_out  <= act_ok_d;
			precharge_ok_out <= pre_ok_d;
			refresh_ok_out   <= ref_ok_d;
			read_ok_out      <= rd_ok_d;
			write_ok_out     <= wrc_ok_d;
		end
	end
endmodule

// file: bench/dcst_cmd_model.sv
// command issuing side: bench requests become one-cycle command pulses
`timescale 1ns/10ps
module dcst_cmd_model
(
	input  wire logic       clock_in, // memory clock
	input  wire logic       nrst_in,  // reset, active low
	input  wire logic       fire_in,  // issue one command
	input  wire logic [2:0] kind_in,  // 0 ref 1 mode 2 pre 3 act 4 read 5 last write
	input  wire logic [2:0] bank_in,  // bank of an activate
	output logic      [5:0] cmd_out,  // one-hot command pulse
	output logic      [2:0] bank_out  // bank, live beside any fired command
);
	// one stage of latency; an idle bank is inverted each cycle so it never looks live
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cmd_out  <= 6'h00;
			bank_out <= 3'h0;
		end
		else
		begin
			cmd_out  <= fire_in ? 6'h01 << kind_in : 6'h00;
			bank_out <= fire_in ? bank_in : ~bank_out;
		end
	end
endmodule

// file: bench/dcst_timer_checker.sv
// concurrent checks of the command spacing timer at its ports
`timescale 1ns/10ps
module dcst_timer_checker
(
	input wire logic        clock_in,
	input wire logic        nrst_in,
	input wire logic [3:0]  reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        cmd_refresh_in,
	input wire logic        cmd_mode_load_in,
	input wire logic        cmd_precharge_in,
	input wire logic        cmd_activate_in,
	input wire logic [2:0]  cmd_bank_in,
	input wire logic        cmd_read_in,
	input wire logic        wr_data_last_in,
	input wire logic [7:0]  activate_ok_out,
	input wire logic [7:0]  precharge_ok_out,
	input wire logic        refresh_ok_out,
	input wire logic        read_ok_out,
	input wire logic        write_ok_out,
	input wire logic        init_start_out,
	input wire logic        ctrl_enable_out
);
	logic [31:0] tim_q;  // shadow timing word
	logic [1:0]  cfg_q;  // shadow unlock and enable
	logic [2:0]  col_q;  // activate to column cycles left
	logic [1:0]  wtr_q;  // write to read cycles left
	wire logic   tim_wr = reg_wr_in && reg_addr_in == 4'h0 && cfg_q[1]; // accepted write
	wire logic   rd_tim = reg_rd_in && reg_addr_in == 4'h0;             // timing read
	wire logic   init_c = tim_wr && cfg_q[0] && reg_wdata_in[18:16] != tim_q[18:16];
	// shadows follow accepted writes; two counters mirror the column gaps
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tim_q <= 32'h552472da;
			cfg_q <= 2'h0;
			col_q <= 3'h0;
			wtr_q <= 2'h0;
		end
		else
		begin
			if (tim_wr)
				tim_q <= reg_wdata_in & 32'hfffffffb;
			if (reg_wr_in && reg_addr_in == 4'h4)
				cfg_q <= reg_wdata_in[1:0];
			col_q <= cmd_activate_in ? tim_q[21:19] : col_q - {2'h0, col_q != 3'h0};
			wtr_q <= wr_data_last_in ? tim_q[1:0] : wtr_q - {1'h0, wtr_q != 2'h0};
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	sequence s_act(f);
		cmd_activate_in && f != 0;
	endsequence
	sequence s_shut;
		!refresh_ok_out && activate_ok_out == 8'h0;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside a read");
	a_timing_back: assert property ($past(rd_tim) |-> reg_rdata_out == $past(tim_q))
		else $error("timing word read back wrong");
	a_enable_copy: assert property (ctrl_enable_out == cfg_q[0])
		else $error("enable copy wrong");
	a_init_start: assert property (init_c |=> init_start_out)
		else $error("init start missing");
	a_init_only: assert property (init_start_out |-> $past(init_c))
		else $error("init start without cause");
	a_col_gap: assert property (write_ok_out == (col_q == 3'h0))
		else $error("write eligibility wrong");
	a_wtr_gap: assert property (read_ok_out == (col_q == 3'h0 && wtr_q == 2'h0))
		else $error("read eligibility wrong");
	a_row_cycle: assert property (s_act(tim_q[10:6]) |=> !activate_ok_out[$past(cmd_bank_in)])
		else $error("same bank activate open");
	a_row_active: assert property (s_act(tim_q[15:11]) |=> !precharge_ok_out[$past(cmd_bank_in)])
		else $error("precharge open after activate");
	a_row_to_row: assert property (s_act(tim_q[5:3]) |=> activate_ok_out == 8'h0)
		else $error("activate open after activate");
	a_refresh_hold: assert property ((cmd_refresh_in || cmd_mode_load_in) && tim_q[31:25] != 7'h0 |=> s_shut)
		else $error("open after refresh");
	a_pre_hold: assert property (cmd_precharge_in && tim_q[24:22] != 3'h0 |=> s_shut)
		else $error("open after precharge");
	a_wr_recover: assert property (wr_data_last_in && tim_q[18:16] != 3'h0 |=> precharge_ok_out == 8'h0)
		else $error("precharge open after write");
endmodule
bind dcst_timer dcst_timer_checker u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cmd_refresh_in(cmd_refresh_in),
	.cmd_mode_load_in(cmd_mode_load_in), .cmd_precharge_in(cmd_precharge_in),
	.cmd_activate_in(cmd_activate_in), .cmd_bank_in(cmd_bank_in), .cmd_read_in(cmd_read_in),
	.wr_data_last_in(wr_data_last_in), .activate_ok_out(activate_ok_out),
	.precharge_ok_out(precharge_ok_out), .refresh_ok_out(refresh_ok_out),
	.read_ok_out(read_ok_out), .write_ok_out(write_ok_out), .init_start_out(init_start_out),
	.ctrl_enable_out(ctrl_enable_out));

// file: bench/ddr2_command_spacing_timer_test.sv
// self-checking bench of the command spacing timer
`timescale 1ns/10ps
`include "dcst_consts.svh"
module ddr2_command_spacing_timer_test;
	localparam int RRD_F = (4 * 150 + 2 * 100) / (4 * 100) - 1; // eight banks, 150 ns row-to-row
	// row-active 9 kept at or above row-to-column 2, reserved bit set on purpose
	localparam logic [31:0] W1 = {7'h05, 3'h3, 3'h2, 3'h6, 5'h09, 5'h0c, RRD_F[2:0], 1'h1, 2'h3};
	localparam logic [31:0] W0 = {`DCST_RST_RFC, `DCST_RST_RP, `DCST_RST_RCD, `DCST_RST_WR,
		`DCST_RST_RAS, `DCST_RST_RC, `DCST_RST_RRD, `DCST_RST_RSVD, `DCST_RST_WTR};
	logic        clock_in = 1'b0;      // memory clock
	logic        nrst_in = 1'b0;       // reset, low at start
	logic [3:0]  reg_addr_in = 4'h0;   // register port
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        fire_q = 1'b0;        // request to the command model
	logic [2:0]  kind_q = 3'h0;
	logic [2:0]  bank_q = 3'h0;
	logic [5:0]  cmd_w;                // command pulses
	logic [2:0]  bank_w;
	logic [31:0] reg_rdata_out;
	logic [7:0]  act_ok;
	logic [7:0]  pre_ok;
	logic        ref_ok, rd_ok, wr_ok, init_w, en_w;
	logic        init_seen;            // init pulse after the last write
	logic [31:0] lows [19];            // low cycles per eligibility bit
	int          err_count = 0;
	int          checks = 0;
	dcst_cmd_model u_cmd (.clock_in(clock_in), .nrst_in(nrst_in), .fire_in(fire_q),
		.kind_in(kind_q), .bank_in(bank_q), .cmd_out(cmd_w), .bank_out(bank_w));
	dcst_timer dut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .cmd_refresh_in(cmd_w[0]), .cmd_mode_load_in(cmd_w[1]),
		.cmd_precharge_in(cmd_w[2]), .cmd_activate_in(cmd_w[3]), .cmd_bank_in(bank_w),
		.cmd_read_in(cmd_w[4]), .wr_data_last_in(cmd_w[5]), .activate_ok_out(act_ok),
		.precharge_ok_out(pre_ok), .refresh_ok_out(ref_ok), .read_ok_out(rd_ok),
		.write_ok_out(wr_ok), .init_start_out(init_w), .ctrl_enable_out(en_w));
	initial forever #50 clock_in = ~clock_in;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one write cycle; the init pulse is looked at in the cycle after it
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
		#1;
		init_seen = init_w;
	endtask
	// one read cycle; data stand only in the following cycle
	task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1;
		check(reg_rdata_out, exp);
	endtask
	// issue one command and count how long each eligibility bit stays low
	task automatic fire(input logic [2:0] k, input logic [2:0] b);
		logic [18:0] v;
		@(posedge clock_in);
		fire_q <= 1'b1;
		kind_q <= k;
		bank_q <= b;
		@(posedge clock_in);
		fire_q <= 1'b0;
		for (int i = 0; i < 19; i++)
			lows[i] = 32'h0;
		repeat (40)
		begin
			@(posedge clock_in);
			#1;
			v = {wr_ok, rd_ok, ref_ok, pre_ok, act_ok};
			for (int i = 0; i < 19; i++)
				lows[i] += {31'h0, ~v[i]};
		end
	endtask
	// expected low cycles: field value of the gap that the command starts
	function automatic logic [31:0] exp_low(input logic [2:0] k, input logic [2:0] b, input int i);
		logic [31:0] v;
		v = 32'h0;
		if (k < 3'h2 && (i < 8 || i == 16))
			v = {25'h0, W1[31:25]};
		if (k == 3'h2 && (i < 8 || i == 16))
			v = {29'h0, W1[24:22]};
		if (k == 3'h3)
			v = (i == b) ? {27'h0, W1[10:6]} : (i < 8) ? {29'h0, W1[5:3]} :
				(i == 8 + b) ? {27'h0, W1[15:11]} : (i > 16) ? {29'h0, W1[21:19]} : 32'h0;
		if (k == 3'h5)
			v = (i >= 8 && i < 16) ? {29'h0, W1[18:16]} : (i == 17) ? {30'h0, W1[1:0]} : 32'h0;
		return v;
	endfunction
	// watchdog, well beyond the roughly 350 cycles the tests need
	initial
	begin
		#400000;
		err_count++;
		close_out;
	end
	initial
	begin
		logic [2:0] kd;
		logic [2:0] bd;
		repeat (20) @(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rd_check(4'h0, W0);
		rd_check(4'h4, 32'h0);
		rd_check(4'h8, 32'h0007ffff);
		rd_check(4'hc, 32'h0);
		reg_write(4'h0, 32'hffffffff);
		rd_check(4'h0, W0);
		reg_write(4'h4, 32'h2);
		reg_write(4'h0, W1);
		check({31'h0, init_seen}, 32'h0);
		rd_check(4'h0, W1 & 32'hfffffffb);
		reg_write(4'h4, 32'h3);
		check({31'h0, en_w}, 32'h1);
		reg_write(4'h0, W1);
		check({31'h0, init_seen}, 32'h0);
		reg_write(4'h0, W1 ^ 32'h00030000);
		check({31'h0, init_seen}, 32'h1);
		reg_write(4'h0, W1);
		check({31'h0, init_seen}, 32'h1);
		reg_write(4'h4, 32'h1);
		reg_write(4'h0, W0);
		check({31'h0, init_seen}, 32'h0);
		reg_write(4'h8, 32'h0);
		rd_check(4'h8, 32'h0007ffff);
		rd_check(4'h0, W1 & 32'hfffffffb);
		for (int k = 0; k < 7; k++)
		begin
			kd = (k == 6) ? 3'h3 : k[2:0];
			bd = (k == 6) ? 3'h7 : 3'h2;
			fire(kd, bd);
			for (int i = 0; i < 19; i++)
				check(lows[i], exp_low(kd, bd, i));
		end
		close_out;
	end
endmodule
